// ### hdl/dmb_bank_sel.sv
/*
 * Data memory bank select: forms 12-bit data addresses, holds the bank
 * enable flag and bank select register, and saves the flag on calls and
 * interrupts. Assumes the core sends one-cycle instruction pulses on
 * ref_clk and keeps the bank select register on its own stack.
 */
`timescale 1ns/1ns
`default_nettype none

module dmb_bank_sel (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Flag and register instructions
    input wire logic bit_set_instr,
    input wire logic bit_clear_instr,
    input wire logic bank_sel_instr,
    input wire logic [dmb_pkg::BANK_W-1:0] bank_sel_value,
    // Explicit push and pop of the select register
    input wire logic bank_push_instr,
    input wire logic bank_pop_instr,
    input wire logic [dmb_pkg::BANK_W-1:0] bank_pop_value,
    // Subroutine and interrupt flow
    input wire logic call_instr,
    input wire logic ret_instr,
    input wire logic int_entry,
    input wire logic int_vec_flag,
    input wire logic int_return,
    // Data access request
    input wire logic acc_valid,
    input wire dmb_pkg::dmb_mode_t acc_mode,
    input wire logic [dmb_pkg::LOW_W-1:0] acc_low,
    input wire logic acc_write,
    input wire logic [dmb_pkg::DATA_W-1:0] acc_wdata,
    // Data access answer
    output logic acc_done,
    output logic [dmb_pkg::ADDR_W-1:0] data_addr,
    output logic ram_sel,
    output logic periph_sel,
    output logic periph_write,
    output logic [dmb_pkg::DATA_W-1:0] periph_wdata,
    output logic unmapped,
    output logic [dmb_pkg::DATA_W-1:0] ram_rdata,
    // Bank state
    output logic bank_enable_flag,
    output logic [dmb_pkg::BANK_W-1:0] bank_select_reg,
    output logic [dmb_pkg::BANK_W-1:0] bank_push_data,
    output logic bank_push_strobe,
    output logic bank_sel_reject,
    output logic flag_stk_overflow,
    output logic flag_stk_underflow
);

    // ==========================================================
    // State
    logic flag_r;
    logic flag_nxt;
    logic [dmb_pkg::BANK_W-1:0] sel_r;
    logic [dmb_pkg::BANK_W-1:0] sel_nxt;
    logic flag_stk_r [dmb_pkg::STK_DEPTH];
    logic [dmb_pkg::STK_PW-1:0] stk_ptr_r;
    logic [dmb_pkg::STK_PW-1:0] stk_ptr_nxt;
    logic acc_done_r;
    logic [dmb_pkg::ADDR_W-1:0] addr_r;
    logic ram_sel_r;
    logic periph_sel_r;
    logic periph_write_r;
    logic [dmb_pkg::DATA_W-1:0] periph_wdata_r;
    logic unmapped_r;
    logic [dmb_pkg::BANK_W-1:0] push_data_r;
    logic push_strobe_r;
    logic reject_r;
    logic ovf_r;
    logic unf_r;

    dmb_ram_if ram_bus ();

    // ==========================================================
    // Flag save and restore
    // Interrupt entry outranks a call in the same cycle; a return that
    // meets a save is dropped, since the core cannot issue both legally.
    wire save_evt = int_entry | call_instr;
    wire restore_evt = (ret_instr | int_return) & ~save_evt;
    wire stk_full = (stk_ptr_r == dmb_pkg::STK_FULL);
    wire stk_empty = (stk_ptr_r == dmb_pkg::STK_EMPTY);
    wire [dmb_pkg::STK_PW-1:0] stk_ptr_dec = stk_ptr_r - dmb_pkg::STK_ONE;
    wire [dmb_pkg::STK_IW-1:0] push_idx = stk_ptr_r[dmb_pkg::STK_IW-1:0];
    wire [dmb_pkg::STK_IW-1:0] pop_idx = stk_ptr_dec[dmb_pkg::STK_IW-1:0];
    wire popped_flag = stk_empty ? dmb_pkg::FLAG_RESET : flag_stk_r[pop_idx];
    wire do_push = save_evt & ~stk_full;
    wire do_pop = restore_evt & ~stk_empty;

    assign stk_ptr_nxt = do_push ? stk_ptr_r + dmb_pkg::STK_ONE :
                         do_pop ? stk_ptr_dec : stk_ptr_r;

    // A bit instruction that meets an interrupt entry or a restore is lost.
    assign flag_nxt = int_entry ? int_vec_flag :
                      restore_evt ? popped_flag :
                      bit_set_instr ? 1'b1 :
                      bit_clear_instr ? 1'b0 :
                      flag_r;

    // ==========================================================
    // Bank select register
    // Values outside the legal set are refused and leave the register as
    // it was, so a bad operand can never point at an unmapped bank.
    wire sel_ok = dmb_pkg::dmb_bank_ok(bank_sel_value);
    wire pop_ok = dmb_pkg::dmb_bank_ok(bank_pop_value);
    wire sel_take = bank_sel_instr & sel_ok;
    wire pop_take = bank_pop_instr & ~bank_sel_instr & pop_ok;
    wire sel_refused = (bank_sel_instr & ~sel_ok) |
                       (bank_pop_instr & ~bank_sel_instr & ~pop_ok);

    assign sel_nxt = sel_take ? bank_sel_value :
                     pop_take ? bank_pop_value : sel_r;

    // ==========================================================
    // Address formation
    wire low_is_high = (acc_low >= dmb_pkg::DIRECT_HIGH_FIRST);
    wire [dmb_pkg::BANK_W-1:0] fixed_bank =
        low_is_high ? dmb_pkg::BANK_15 : dmb_pkg::BANK_0;
    wire [dmb_pkg::BANK_W-1:0] direct_bank =
        flag_r ? sel_r : fixed_bank;
    wire [dmb_pkg::BANK_W-1:0] banked_bank =
        flag_r ? sel_r : dmb_pkg::BANK_0;
    logic [dmb_pkg::BANK_W-1:0] act_bank;

    always_comb begin
        case (acc_mode)
            dmb_pkg::DMB_MODE_DIRECT: begin
                act_bank = direct_bank;
            end
            dmb_pkg::DMB_MODE_IND_BANKED: begin
                act_bank = banked_bank;
            end
            dmb_pkg::DMB_MODE_IND_BANK0: begin
                act_bank = dmb_pkg::BANK_0;
            end
            default: begin
                act_bank = dmb_pkg::BANK_0;
            end
        endcase
    end

    wire [dmb_pkg::ADDR_W-1:0] acc_addr = {act_bank, acc_low};
    wire hit_ram = dmb_pkg::dmb_in_ram(acc_addr);
    wire hit_periph = dmb_pkg::dmb_in_periph(acc_addr);

    // Only accesses that land in the RAM window enable the array, so
    // peripheral and unmapped cycles leave its contents and read latch alone.
    assign ram_bus.en = acc_valid & hit_ram;
    assign ram_bus.we = acc_write;
    assign ram_bus.addr = acc_addr[dmb_pkg::RAM_AW-1:0];
    assign ram_bus.wdata = acc_wdata;

    dmb_sram dmb_sram_i (
        .ref_clk(ref_clk),
        .ram(ram_bus.mem)
    );

    // ==========================================================
    // Registers
    // Each register keeps its own short block, with its reset value beside it.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_r <= dmb_pkg::FLAG_RESET;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_r <= dmb_pkg::BANK_SEL_RESET;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stk_ptr_r <= dmb_pkg::STK_EMPTY;
        end else begin
            stk_ptr_r <= stk_ptr_nxt;
        end
    end

    // ==========================================================
    // Flag save stack
    // One flop per entry, loaded only when the push index points at it.
    // The pointer guards every read, so an entry never saved is never seen.
    genvar gi;

    for (gi = 0; gi < dmb_pkg::STK_DEPTH; gi++) begin : g_flag_stk
        wire entry_load = do_push & (int'(push_idx) == gi);
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                flag_stk_r[gi] <= dmb_pkg::FLAG_RESET;
            end else if (entry_load) begin
                flag_stk_r[gi] <= flag_r;
            end
        end
    end

    // ==========================================================
    // Access answer
    // Address and write data hold between accesses so the far side can
    // read them back at leisure; the selects are one-cycle pulses.
    wire [dmb_pkg::ADDR_W-1:0] addr_nxt = acc_valid ? acc_addr : addr_r;
    wire [dmb_pkg::DATA_W-1:0] periph_wdata_nxt = acc_valid ? acc_wdata : periph_wdata_r;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_done_r <= 1'b0;
            ram_sel_r <= 1'b0;
            periph_sel_r <= 1'b0;
            periph_write_r <= 1'b0;
            unmapped_r <= 1'b0;
        end else begin
            acc_done_r <= acc_valid;
            ram_sel_r <= acc_valid & hit_ram;
            periph_sel_r <= acc_valid & hit_periph;
            periph_write_r <= acc_valid & hit_periph & acc_write;
            unmapped_r <= acc_valid & ~hit_ram & ~hit_periph;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_r <= dmb_pkg::RAM_FIRST;
            periph_wdata_r <= '0;
        end else begin
            addr_r <= addr_nxt;
            periph_wdata_r <= periph_wdata_nxt;
        end
    end

    // ==========================================================
    // Push, refusal and stack status
    wire [dmb_pkg::BANK_W-1:0] push_data_nxt = bank_push_instr ? sel_r : push_data_r;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            push_data_r <= dmb_pkg::BANK_SEL_RESET;
            push_strobe_r <= 1'b0;
        end else begin
            push_data_r <= push_data_nxt;
            push_strobe_r <= bank_push_instr;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reject_r <= 1'b0;
        end else begin
            reject_r <= sel_refused;
        end
    end

    // Overflow drops the save and underflow restores a cleared flag; both
    // are reported so the core can trap a runaway call depth.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ovf_r <= 1'b0;
            unf_r <= 1'b0;
        end else begin
            ovf_r <= save_evt & stk_full;
            unf_r <= restore_evt & stk_empty;
        end
    end

    // ==========================================================
    // Outputs
    assign acc_done = acc_done_r;
    assign data_addr = addr_r;
    assign ram_sel = ram_sel_r;
    assign periph_sel = periph_sel_r;
    assign periph_write = periph_write_r;
    assign periph_wdata = periph_wdata_r;
    assign unmapped = unmapped_r;
    assign ram_rdata = ram_bus.rdata;
    assign bank_enable_flag = flag_r;
    assign bank_select_reg = sel_r;
    assign bank_push_data = push_data_r;
    assign bank_push_strobe = push_strobe_r;
    assign bank_sel_reject = reject_r;
    assign flag_stk_overflow = ovf_r;
    assign flag_stk_underflow = unf_r;

endmodule : dmb_bank_sel

`default_nettype wire

// ### include/dmb_pkg.sv
/*
 * Constants, types and decode functions for the data memory bank select block.
 * Assumes a 4-bit core with 12-bit data addresses and one clock domain.
 */
`default_nettype none

package dmb_pkg;

    // ==========================================================
    // Widths and sizes
    localparam int DATA_W = 4;
    localparam int LOW_W = 8;
    localparam int BANK_W = 4;
    localparam int ADDR_W = 12;
    localparam int RAM_AW = 10;
    localparam int RAM_WORDS = 1024;
    localparam int STK_DEPTH = 16;
    localparam int STK_PW = 5;
    localparam int STK_IW = 4;

    // ==========================================================
    // Address map
    localparam logic [ADDR_W-1:0] RAM_FIRST = 12'h000;
    localparam logic [ADDR_W-1:0] RAM_LAST = 12'h3FF;
    localparam logic [ADDR_W-1:0] PERIPH_FIRST = 12'hF80;
    localparam logic [ADDR_W-1:0] PERIPH_LAST = 12'hFFF;
    localparam logic [LOW_W-1:0] DIRECT_HIGH_FIRST = 8'h80;

    // ==========================================================
    // Bank numbers and reset values
    localparam logic [BANK_W-1:0] BANK_0 = 4'h0;
    localparam logic [BANK_W-1:0] BANK_1 = 4'h1;
    localparam logic [BANK_W-1:0] BANK_2 = 4'h2;
    localparam logic [BANK_W-1:0] BANK_3 = 4'h3;
    localparam logic [BANK_W-1:0] BANK_15 = 4'hF;
    localparam logic [BANK_W-1:0] BANK_SEL_RESET = 4'h0;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [STK_PW-1:0] STK_EMPTY = 5'h00;
    localparam logic [STK_PW-1:0] STK_FULL = 5'h10;
    localparam logic [STK_PW-1:0] STK_ONE = 5'h01;

    // ==========================================================
    // Access modes
    typedef enum logic [1:0] {
        DMB_MODE_DIRECT = 2'b00,
        DMB_MODE_IND_BANKED = 2'b01,
        DMB_MODE_IND_BANK0 = 2'b10,
        DMB_MODE_SPARE = 2'b11
    } dmb_mode_t;

    // ==========================================================
    // Decode functions
    function automatic logic dmb_bank_ok(input logic [BANK_W-1:0] b);
        dmb_bank_ok = (b == BANK_0) || (b == BANK_1) || (b == BANK_2) ||
                      (b == BANK_3) || (b == BANK_15);
    endfunction : dmb_bank_ok

    function automatic logic dmb_in_ram(input logic [ADDR_W-1:0] a);
        dmb_in_ram = (a >= RAM_FIRST) && (a <= RAM_LAST);
    endfunction : dmb_in_ram

    function automatic logic dmb_in_periph(input logic [ADDR_W-1:0] a);
        dmb_in_periph = (a >= PERIPH_FIRST) && (a <= PERIPH_LAST);
    endfunction : dmb_in_periph

endpackage : dmb_pkg

`default_nettype wire

// ### include/dmb_ram_if.sv
/*
 * Carrier between the bank select logic and its static RAM.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface dmb_ram_if;
    logic en;
    logic we;
    logic [dmb_pkg::RAM_AW-1:0] addr;
    logic [dmb_pkg::DATA_W-1:0] wdata;
    logic [dmb_pkg::DATA_W-1:0] rdata;

    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : dmb_ram_if

`default_nettype wire

// ### hdl/dmb_sram.sv
/*
 * Static RAM of 1024 words of four bits with a registered read port.
 * Assumes one access per cycle; write and read share the port.
 */
`timescale 1ns/1ns
`default_nettype none

module dmb_sram (
    // Clock
    input wire logic ref_clk,
    // Memory port
    dmb_ram_if.mem ram
);

    // ==========================================================
    // Storage
    // The array has no reset, so contents are undefined until written.
    logic [dmb_pkg::DATA_W-1:0] mem_r [dmb_pkg::RAM_WORDS];
    logic [dmb_pkg::DATA_W-1:0] rdata_r;

    always_ff @(posedge ref_clk) begin
        if (ram.en && ram.we) begin
            mem_r[ram.addr] <= ram.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (ram.en && !ram.we) begin
            rdata_r <= mem_r[ram.addr];
        end
    end

    assign ram.rdata = rdata_r;

endmodule : dmb_sram

`default_nettype wire

// ### test/dmb_core_model.sv
/* Core side stack that keeps the bank select register across explicit push and pop.
   Assumes one-cycle push strobes and pop requests on ref_clk. */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Core stack model
module dmb_core_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Push from the block
    input wire logic push_strobe,
    input wire logic [dmb_pkg::BANK_W-1:0] push_data,
    // Pop towards the block
    input wire logic pop_take,
    output logic [dmb_pkg::BANK_W-1:0] pop_value
);
    logic [dmb_pkg::BANK_W-1:0] stk_r [0:7];
    logic [2:0] sp_r;
    // An empty stack shows an inverted word so a stale bank 1, 2 or 3 cannot pass.
    assign pop_value = (sp_r != 3'h0) ? stk_r[sp_r - 3'h1] : ~stk_r[0];
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sp_r <= 3'h0;
        end else if (push_strobe) begin
            stk_r[sp_r] <= push_data;
            sp_r <= sp_r + 3'h1;
        end else if (pop_take && sp_r != 3'h0) begin
            sp_r <= sp_r - 3'h1;
        end
    end
endmodule : dmb_core_model
`default_nettype wire

// ### test/dmb_bank_sel_properties.sv
/* Timing and decode properties of the bank select block.
   Assumes one clock and the asynchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Checker
module dmb_bank_sel_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Watched inputs
    input wire logic bit_set_instr,
    input wire logic ret_instr,
    input wire logic int_entry,
    input wire logic int_return,
    input wire logic bank_sel_instr,
    input wire logic [dmb_pkg::BANK_W-1:0] bank_sel_value,
    input wire logic bank_push_instr,
    input wire logic acc_valid,
    input wire dmb_pkg::dmb_mode_t acc_mode,
    input wire logic [dmb_pkg::LOW_W-1:0] acc_low,
    // Watched outputs
    input wire logic acc_done,
    input wire logic [dmb_pkg::ADDR_W-1:0] data_addr,
    input wire logic ram_sel,
    input wire logic periph_sel,
    input wire logic bank_enable_flag,
    input wire logic [dmb_pkg::BANK_W-1:0] bank_select_reg,
    input wire logic [dmb_pkg::BANK_W-1:0] bank_push_data,
    input wire logic bank_push_strobe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_fixed_acc;
        acc_valid && !bank_enable_flag && acc_mode == dmb_pkg::DMB_MODE_DIRECT;
    endsequence
    sequence s_banked_acc;
        acc_valid && bank_enable_flag && !acc_mode[1];
    endsequence
    a_done_one_cycle: assert property (
        acc_valid |=> acc_done ##1 (acc_done == $past(acc_valid)))
        else $error("done timing");
    a_direct_low_bank: assert property (
        s_fixed_acc ##0 !acc_low[7] |=> data_addr == {4'h0, $past(acc_low)})
        else $error("bank 0 address");
    a_direct_high_bank: assert property (
        s_fixed_acc ##0 acc_low[7] |=> data_addr == {4'hF, $past(acc_low)} && periph_sel)
        else $error("bank 15 address");
    a_select_bank_used: assert property (
        s_banked_acc |=> data_addr == {$past(bank_select_reg), $past(acc_low)})
        else $error("selected bank");
    a_ram_decode: assert property (
        acc_done |-> ram_sel == (data_addr <= 12'h3FF))
        else $error("ram select");
    a_periph_decode: assert property (
        acc_done |-> periph_sel == (data_addr >= 12'hF80))
        else $error("periph select");
    a_select_legal: assert property (
        bank_select_reg inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hF})
        else $error("illegal bank held");
    a_select_load: assert property (
        bank_sel_instr && (bank_sel_value inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hF})
        |=> bank_select_reg == $past(bank_sel_value))
        else $error("select load");
    a_flag_set: assert property (
        bit_set_instr && !int_entry && !ret_instr && !int_return |=> bank_enable_flag)
        else $error("flag set");
    a_push_data: assert property (
        bank_push_instr |=> bank_push_strobe && bank_push_data == $past(bank_select_reg))
        else $error("push data");
endmodule : dmb_bank_sel_properties
bind dmb_bank_sel dmb_bank_sel_properties dmb_bank_sel_properties_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .bit_set_instr(bit_set_instr), .ret_instr(ret_instr),
    .int_entry(int_entry), .int_return(int_return), .bank_sel_instr(bank_sel_instr),
    .bank_sel_value(bank_sel_value), .bank_push_instr(bank_push_instr), .acc_valid(acc_valid),
    .acc_mode(acc_mode), .acc_low(acc_low), .acc_done(acc_done), .data_addr(data_addr),
    .ram_sel(ram_sel), .periph_sel(periph_sel), .bank_enable_flag(bank_enable_flag),
    .bank_select_reg(bank_select_reg), .bank_push_data(bank_push_data),
    .bank_push_strobe(bank_push_strobe));
`default_nettype wire

// ### test/data_memory_bank_select_test.sv
/* Self-checking bench for the bank select block with a core stack model.
   Assumes a 50 ns clock; inputs change 1 ns after each rising edge. */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bench top
module data_memory_bank_select_test;
    logic ref_clk = 1'b0, arst_n = 1'b0, bit_set_instr = 1'b0, bit_clear_instr = 1'b0;
    logic bank_sel_instr = 1'b0, bank_push_instr = 1'b0, bank_pop_instr = 1'b0;
    logic call_instr = 1'b0, ret_instr = 1'b0, int_entry = 1'b0, int_vec_flag = 1'b0;
    logic int_return = 1'b0, acc_valid = 1'b0, acc_write = 1'b0;
    logic [3:0] bank_sel_value = 4'h0, acc_wdata = 4'h0, bank_pop_value;
    logic [7:0] acc_low = 8'h00;
    dmb_pkg::dmb_mode_t acc_mode = dmb_pkg::DMB_MODE_DIRECT;
    logic acc_done, ram_sel, periph_sel, periph_write, unmapped, bank_enable_flag;
    logic bank_push_strobe, bank_sel_reject, flag_stk_overflow, flag_stk_underflow;
    logic [11:0] data_addr;
    logic [3:0] periph_wdata, ram_rdata, bank_select_reg, bank_push_data;
    int bad_count = 0, n_compared = 0;
    always #25 ref_clk = ~ref_clk;
    dmb_bank_sel dmb_bank_sel_i (.ref_clk(ref_clk), .arst_n(arst_n),
        .bit_set_instr(bit_set_instr), .bit_clear_instr(bit_clear_instr),
        .bank_sel_instr(bank_sel_instr), .bank_sel_value(bank_sel_value),
        .bank_push_instr(bank_push_instr), .bank_pop_instr(bank_pop_instr),
        .bank_pop_value(bank_pop_value), .call_instr(call_instr), .ret_instr(ret_instr),
        .int_entry(int_entry), .int_vec_flag(int_vec_flag), .int_return(int_return),
        .acc_valid(acc_valid), .acc_mode(acc_mode), .acc_low(acc_low), .acc_write(acc_write),
        .acc_wdata(acc_wdata), .acc_done(acc_done), .data_addr(data_addr), .ram_sel(ram_sel),
        .periph_sel(periph_sel), .periph_write(periph_write), .periph_wdata(periph_wdata),
        .unmapped(unmapped), .ram_rdata(ram_rdata), .bank_enable_flag(bank_enable_flag),
        .bank_select_reg(bank_select_reg), .bank_push_data(bank_push_data),
        .bank_push_strobe(bank_push_strobe), .bank_sel_reject(bank_sel_reject),
        .flag_stk_overflow(flag_stk_overflow), .flag_stk_underflow(flag_stk_underflow));
    dmb_core_model dmb_core_model_i (.ref_clk(ref_clk), .arst_n(arst_n),
        .push_strobe(bank_push_strobe), .push_data(bank_push_data),
        .pop_take(bank_pop_instr), .pop_value(bank_pop_value));
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask : pulse
    task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // An idle edge before each access or select keeps a strobe from being
    // lowered and raised again in one time step by back-to-back calls.
    task automatic acc(input dmb_pkg::dmb_mode_t m, input logic [7:0] lo, input logic w);
        tick();
        acc_mode = m;
        acc_low = lo;
        acc_write = w;
        pulse(acc_valid);
    endtask : acc
    task automatic sel(input logic [3:0] v);
        tick();
        bank_sel_value = v;
        pulse(bank_sel_instr);
    endtask : sel
    task automatic t_fixed_bank();
        sel(4'h1);
        acc(dmb_pkg::DMB_MODE_DIRECT, 8'h7F, 1'b0);
        chk("addr", data_addr, 12'h07F);
        chk("ram", ram_sel, 1'b1);
        acc_wdata = 4'h9;
        acc(dmb_pkg::DMB_MODE_DIRECT, 8'h80, 1'b1);
        chk("addr", data_addr, 12'hF80);
        chk("pwrite", {periph_write, periph_wdata}, 5'h19);
        acc(dmb_pkg::DMB_MODE_IND_BANKED, 8'h44, 1'b0);
        chk("addr", data_addr, 12'h044);
    endtask : t_fixed_bank
    task automatic t_banked();
        pulse(bit_set_instr);
        chk("flag", bank_enable_flag, 1'b1);
        acc_wdata = 4'h5;
        acc(dmb_pkg::DMB_MODE_DIRECT, 8'h1A, 1'b1);
        chk("addr", data_addr, 12'h11A);
        acc(dmb_pkg::DMB_MODE_IND_BANKED, 8'h1A, 1'b0);
        chk("rdata", {acc_done, ram_rdata}, 5'h15);
        sel(4'hF);
        acc(dmb_pkg::DMB_MODE_DIRECT, 8'h10, 1'b0);
        chk("unmapped", {unmapped, ram_sel, periph_sel}, 3'h4);
        acc(dmb_pkg::DMB_MODE_IND_BANK0, 8'hC3, 1'b0);
        chk("addr", data_addr, 12'h0C3);
        acc(dmb_pkg::DMB_MODE_SPARE, 8'h2B, 1'b0);
        chk("addr", data_addr, 12'h02B);
    endtask : t_banked
    task automatic t_select_codes();
        logic [3:0] hold;
        hold = bank_select_reg;
        for (int v = 0; v < 16; v++) begin
            sel(v[3:0]);
            if (v < 4 || v == 15) begin
                hold = v[3:0];
            end
            chk("bank_sel", bank_select_reg, hold);
            chk("reject", bank_sel_reject, (v > 3 && v < 15));
        end
    endtask : t_select_codes
    task automatic t_flag_save();
        pulse(call_instr);
        pulse(bit_clear_instr);
        chk("flag", bank_enable_flag, 1'b0);
        pulse(ret_instr);
        chk("flag", bank_enable_flag, 1'b1);
        int_vec_flag = 1'b0;
        pulse(int_entry);
        chk("flag", bank_enable_flag, 1'b0);
        pulse(bit_set_instr);
        pulse(bit_clear_instr);
        pulse(int_return);
        chk("flag", bank_enable_flag, 1'b1);
    endtask : t_flag_save
    task automatic t_push_pop();
        sel(4'h3);
        pulse(bank_push_instr);
        chk("push", {bank_push_strobe, bank_push_data}, 5'h13);
        pulse(call_instr);
        chk("bank_sel", bank_select_reg, 4'h3);
        sel(4'h1);
        pulse(bank_pop_instr);
        chk("bank_sel", bank_select_reg, 4'h3);
        tick();
        pulse(bank_pop_instr);
        chk("pop_reject", {bank_sel_reject, bank_select_reg}, 5'h13);
    endtask : t_push_pop
    task automatic t_flag_stack();
        pulse(int_return);
        chk("underflow", {flag_stk_underflow, bank_enable_flag}, 2'h1);
        pulse(ret_instr);
        chk("underflow", {flag_stk_underflow, bank_enable_flag}, 2'h2);
        for (int i = 0; i < 17; i++) begin
            tick();
            pulse(call_instr);
            chk("overflow", flag_stk_overflow, i == 16);
            if (i == 0) begin
                pulse(bit_set_instr);
            end
        end
        for (int i = 0; i < 16; i++) begin
            tick();
            pulse(ret_instr);
            chk("restore", bank_enable_flag, i < 15);
        end
    endtask : t_flag_stack
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        chk("reset", {bank_enable_flag, bank_select_reg}, 5'h00);
        t_fixed_bank();
        t_banked();
        t_select_codes();
        t_flag_save();
        t_push_pop();
        t_flag_stack();
        final_report();
    end
    // The whole run needs about 150 cycles; a limit of 2000 leaves a wide margin.
    initial begin
        #100000;
        bad_count++;
        final_report();
    end
endmodule : data_memory_bank_select_test
`default_nettype wire
